// file: rtl/flash_adc_output_interface.sv
// digital side of an 8-bit flash converter: sampling, coding, output latch, enables
`timescale 1ns/1ps
`include "adc_params.svh"

// How it works
// - all_output_enable low floats result bits and overrange flag regardless of other enable
// - with all_output_enable high, data_output_enable_n low drives bits; flag always driven
// - result is unsigned straight binary, step is span over 256, msb highest
// - input at or above top minus half step gives all ones plus overrange
// - input below half step above bottom gives all zeros, overrange clear
// - exactly one conversion per conversion clock cycle
// - new sample taken on each rising conversion clock edge
// - bits and flag loaded together on a falling conversion clock edge
// - result appears one and a half cycles after its sample
module flash_adc_output_interface
	import adc_pkg::*;
#(
	parameter int IN_W   = `ADC_IN_W,
	parameter int CODE_W = `ADC_CODE_W
) (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              conv_clk,
	input  wire logic [IN_W-1:0]   analog_level,
	input  wire logic              all_output_enable,
	input  wire logic              data_output_enable_n,
	output logic [CODE_W-1:0]      result_bits,
	output logic                   result_bits_oe,
	output logic                   overrange_flag,
	output logic                   overrange_flag_oe,
	output logic                   stream_valid,
	output logic [CODE_W:0]        stream_data,
	input  wire logic              stream_ready,
	output logic                   stream_in_ready
);

	top_state_t st_r;
	top_state_t st_nxt;
	logic       rise;
	logic       fall;

	// ----------------------------------------
	// coding of one sample
	// ----------------------------------------
	// the level is counted in half steps, so rounding gives the half-step thresholds
	function automatic result_t encode(input level_t x);
		level_t xr;
		xr = x + `ADC_IN_ONE;
		if (x >= `ADC_OVF_LEVEL)
			encode = {1'b1, `ADC_CODE_ALL1};
		else
			encode = {1'b0, xr[CODE_W:1]};
	endfunction : encode

	// ----------------------------------------
	// conversion clock edges
	// ----------------------------------------
	assign rise = conv_clk && !st_r.clk_d;
	assign fall = !conv_clk && st_r.clk_d;

	// ----------------------------------------
	// pipeline and enables
	// ----------------------------------------
	always_comb
	begin
		st_nxt       = st_r;
		st_nxt.clk_d = conv_clk;
		st_nxt.push  = 1'b0;
		if (rise)
		begin
			st_nxt.samp  = analog_level;
			st_nxt.stage = encode(st_r.samp);
		end
		if (fall)
		begin
			st_nxt.out  = st_r.stage;
			st_nxt.push = 1'b1;
		end
		st_nxt.ovf_oe  = all_output_enable;
		st_nxt.data_oe = all_output_enable && !data_output_enable_n;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign result_bits       = st_r.out[CODE_W-1:0];
	assign overrange_flag    = st_r.out[CODE_W];
	assign result_bits_oe    = st_r.data_oe;
	assign overrange_flag_oe = st_r.ovf_oe;

	// ----------------------------------------
	// result stream buffer
	// ----------------------------------------
	result_skid_buffer #(
		.W (`ADC_RES_W)
	) u_buf (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.in_valid  (st_r.push),
		.in_data   (st_r.out),
		.in_ready  (stream_in_ready),
		.out_valid (stream_valid),
		.out_data  (stream_data),
		.out_ready (stream_ready)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_all_float: assert property (!all_output_enable |=> !result_bits_oe && !overrange_flag_oe)
		else $error("outputs driven while all enable low");
	a_data_float: assert property (all_output_enable && data_output_enable_n
		|=> !result_bits_oe && overrange_flag_oe)
		else $error("data enable gating wrong");
	a_data_drive: assert property (all_output_enable && !data_output_enable_n
		|=> result_bits_oe && overrange_flag_oe)
		else $error("data not driven when both enables select");
	a_ovf_ones: assert property (overrange_flag |-> result_bits == `ADC_CODE_ALL1)
		else $error("overrange without all ones");
	a_ovf_code: assert property (rise && st_r.samp >= `ADC_OVF_LEVEL
		|=> st_r.stage == {1'b1, `ADC_CODE_ALL1})
		else $error("overrange level not coded as 511");
	a_zero_code: assert property (rise && st_r.samp == `ADC_IN_ZERO
		|=> st_r.stage == `ADC_RES_ZERO)
		else $error("bottom level not coded as zero");
	a_sample_take: assert property (rise |=> st_r.samp == $past(analog_level))
		else $error("sample not taken on rising edge");
	a_one_conv: assert property (!rise |=> $stable(st_r.samp) && $stable(st_r.stage))
		else $error("conversion outside a rising edge");
	a_out_hold: assert property (!fall |=> $stable(st_r.out))
		else $error("output changed away from falling edge");
	a_out_load: assert property (fall |=> st_r.out == $past(st_r.stage))
		else $error("output not loaded from encoder on falling edge");

	c_overrange: cover property (fall && st_r.stage[CODE_W]);
	c_data_float: cover property (all_output_enable && data_output_enable_n);
	c_buf_full: cover property (!stream_in_ready);
	c_pop: cover property (stream_valid && stream_ready);

endmodule : flash_adc_output_interface

// file: rtl/adc_params.svh
// constants for the flash converter output interface
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

`define ADC_IN_W        10
`define ADC_CODE_W      8
`define ADC_RES_W       9
`define ADC_OVF_LEVEL   10'h1FF
`define ADC_CODE_ALL1   8'hFF
`define ADC_CODE_ZERO   8'h00
`define ADC_RES_ZERO    9'h000
`define ADC_IN_ZERO     10'h000
`define ADC_IN_ONE      10'h001
`define ADC_BUF_W       9

`endif

// file: rtl/adc_pkg.sv
// types shared by the flash converter output interface
`include "adc_params.svh"

package adc_pkg;

	typedef logic [`ADC_IN_W-1:0]   level_t;
	typedef logic [`ADC_RES_W-1:0]  result_t;

	typedef struct packed {
		logic     clk_d;
		level_t   samp;
		result_t  stage;
		result_t  out;
		logic     data_oe;
		logic     ovf_oe;
		logic     push;
	} top_state_t;

endpackage : adc_pkg

// file: rtl/result_skid_buffer.sv
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "adc_params.svh"

module result_skid_buffer #(
	parameter int W = `ADC_BUF_W
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);

	typedef struct packed {
		logic         v0;
		logic         v1;
		logic         rdy;
		logic [W-1:0] m0;
		logic [W-1:0] m1;
	} buf_state_t;

	buf_state_t st_r;
	buf_state_t st_nxt;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		if (st_r.v0 && out_ready)
		begin
			st_nxt.m0 = st_r.m1;
			st_nxt.v0 = st_r.v1;
			st_nxt.v1 = 1'b0;
		end
		// push is only taken while the second slot is free
		if (in_valid && !st_r.v1)
		begin
			if (!st_nxt.v0)
			begin
				st_nxt.m0 = in_data;
				st_nxt.v0 = 1'b1;
			end
			else
			begin
				st_nxt.m1 = in_data;
				st_nxt.v1 = 1'b1;
			end
		end
		// ready is kept in its own flop so the port comes straight from a register
		st_nxt.rdy = !st_nxt.v1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			st_r <= '{v0: 1'b0, v1: 1'b0, rdy: 1'b1, m0: '0, m1: '0};
		else
			st_r <= st_nxt;
	end

	assign in_ready  = st_r.rdy;
	assign out_valid = st_r.v0;
	assign out_data  = st_r.m0;

endmodule : result_skid_buffer

// file: testbench/host_capture_model.sv
// host side: conversion clock source and result consumer
`timescale 1ns/1ps

module host_capture_model (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic stall,
	output logic      conv_clk,
	output logic      stream_ready
);
	int cnt_r;

	always @(posedge clk_sys)
	begin
		stream_ready <= !stall && ($urandom % 4 != 0);
		if (sys_rst)
		begin
			conv_clk <= 1'b0;
			cnt_r <= 4;
		end
		else if (cnt_r == 0)
		begin
			conv_clk <= !conv_clk;
			cnt_r <= 2 + $urandom % 6;
		end
		else
			cnt_r <= cnt_r - 1;
	end
endmodule : host_capture_model

// file: testbench/tb.sv
// self-checking bench for the flash converter output interface
`timescale 1ns/1ps

module tb;
	logic       clk_sys = 1'b0;
	logic       sys_rst = 1'b1;
	logic       stall = 1'b0;
	logic [9:0] analog_level = 10'h000;
	logic       all_output_enable = 1'b0;
	logic       data_output_enable_n = 1'b1;
	logic       conv_clk, result_bits_oe, overrange_flag, overrange_flag_oe;
	logic       stream_valid, stream_ready, stream_in_ready, cprev, e_all, e_n;
	logic [7:0] result_bits;
	logic [8:0] stream_data, exp_w;
	logic [1:0] fall_d;
	int         samp_m, stage_m, out_m, miscompares, cmp_count;
	int         q[$];
	int         lv[8] = '{0, 1, 2, 509, 510, 511, 512, 1023};

	always #50 clk_sys = ~clk_sys;

	flash_adc_output_interface i_flash_adc_output_interface (.clk_sys, .sys_rst,
		.conv_clk, .analog_level, .all_output_enable, .data_output_enable_n,
		.result_bits, .result_bits_oe, .overrange_flag, .overrange_flag_oe,
		.stream_valid, .stream_data, .stream_ready, .stream_in_ready);

	host_capture_model i_host_capture_model (.clk_sys, .sys_rst, .stall,
		.conv_clk, .stream_ready);

	function automatic int enc(int x);
		return (x >= 511) ? 511 : (x + 1) / 2;
	endfunction : enc

	task automatic check(string nm, logic [8:0] seen, logic [8:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			{cprev, fall_d, e_all, e_n} <= 5'h01;
			{samp_m, stage_m, out_m} <= '0;
			q.delete();
		end
		else
		begin
			check("in_ready", 9'(stream_in_ready), 9'(q.size() < 2));
			check("valid", 9'(stream_valid), 9'(q.size() != 0));
			check("bits_oe", 9'(result_bits_oe), 9'(e_all && !e_n));
			check("ovf_oe", 9'(overrange_flag_oe), 9'(e_all));
			e_all <= all_output_enable;
			e_n <= data_output_enable_n;
			cprev <= conv_clk;
			fall_d <= {fall_d[0], !conv_clk && cprev};
			if (conv_clk && !cprev)
			begin
				samp_m <= int'(analog_level);
				stage_m <= enc(samp_m);
			end
			if (!conv_clk && cprev)
				out_m <= stage_m;
			if (fall_d[0] && q.size() < 2)
				q.push_back(out_m);
			if (fall_d[1])
				check("result", {overrange_flag, result_bits}, 9'(out_m));
			if (stream_valid && stream_ready)
			begin
				exp_w = q.size() != 0 ? 9'(q.pop_front()) : 'x;
				check("stream", stream_data, exp_w);
			end
		end
	end

	initial
	begin
		void'($urandom(32'hD912));
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		all_output_enable <= 1'b1;
		data_output_enable_n <= 1'b0;
		foreach (lv[i])
		begin
			analog_level <= 10'(lv[i]);
			repeat (16) @(posedge clk_sys);
		end
		stall <= 1'b1;
		repeat (60) @(posedge clk_sys);
		stall <= 1'b0;
		repeat (400)
		begin
			@(posedge clk_sys);
			analog_level <= 10'($urandom);
			all_output_enable <= ($urandom % 4 != 0);
			data_output_enable_n <= 1'($urandom);
			stall <= ($urandom % 8 == 0);
		end
		stall <= 1'b0;
		repeat (40) @(posedge clk_sys);
		tally_and_finish;
	end

	initial
	begin
		#(2000 * 100);
		miscompares++;
		tally_and_finish;
	end
endmodule : tb
